// ### rtl/psp_pkg.sv
// Package with constants and carrier types for the parallel slave port.
package psp_pkg;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned PSP_SEL_BIT = 4;
  localparam int unsigned PSP_IBF_BIT = 7;
  localparam int unsigned PSP_OBF_BIT = 6;
  localparam int unsigned PSP_OVR_BIT = 5;
  localparam int unsigned PSP_IRQ_BIT = 7;
  localparam int unsigned PSP_DATA_W = 8;
  localparam logic [3:0] PSP_ANALOG_DIGITAL = 4'h6;

  // ==========================================================================
  // Reset values and phase counts
  // ==========================================================================
  localparam logic [7:0] PSP_LATCH_RST = 8'h00;
  localparam logic [1:0] PSP_PH_TWO = 2'h1;
  localparam logic [1:0] PSP_PH_FOUR = 2'h3;
  localparam int unsigned PSP_SYNC_STAGES = 2;

  // Firmware side of the port: strobes are one-cycle pulses.
  typedef struct packed {
    logic [7:0] wdata;
    logic wr_data;
    logic rd_data;
    logic clr_ovr;
    logic clr_irq;
  } psp_fw_req_t;

  // Status seen by firmware.
  typedef struct packed {
    logic input_full_flag;
    logic output_full_flag;
    logic ovr;
    logic irq_flag;
  } psp_status_t;

  // Pending flag update waiting for the phase window.
  typedef enum logic [1:0] {
    PSP_ST_IDLE = 2'b00,
    PSP_ST_WAIT2 = 2'b01,
    PSP_ST_WAIT4 = 2'b10
  } psp_pend_t;

endpackage : psp_pkg

// ### rtl/psp_port.sv
// Parallel slave port: two data latches, strobe logic and status flags.
//
// Behaviour
// - Select bit enables 8-bit slave port
// - External accesses taken asynchronous to core clock
// - Port E pins become read, write, select
// - Strobes work only with direction bits input
// - Strobes need digital analog pin configuration
// - Separate input and output latches, shared address
// - Data direction register ignored in slave mode
// - Write active while select and write low
// - Write end latches data, sets flags phased
// - Latch read clears input full; irq sticky
// - Write while full sets overrun, overwrites
// - Overrun clears after read and clear write
// - Read drives output latch, clears output full
// - Firmware write during read outputs immediately
// - Read end releases pins, sets irq phased
// - Output full stays low until firmware write
// - Mode off holds full flags clear
// - Irq flag firmware cleared; enable masks request
`timescale 1ns/100ps
module psp_port (
  input wire logic i_core_clk, // Core clock, 125 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [7:0] i_port_e_direction, // Port E direction bits.
  input wire logic [3:0] i_analog_pin_config, // Converter pin config.
  input wire logic [7:0] i_data_pin_direction, // Data direction bits.
  input wire logic [7:0] i_port_out_latch, // Normal-mode output data.
  input wire logic i_rd_n, // External read strobe, active low.
  input wire logic i_wr_n, // External write strobe, active low.
  input wire logic i_cs_n, // External chip select, active low.
  input wire logic [7:0] i_pins, // Data pin levels.
  input wire psp_pkg::psp_fw_req_t i_fw, // Firmware requests.
  input wire logic i_irq_enable, // Port interrupt enable.
  output logic [7:0] o_pins, // Data pin output value.
  output logic [7:0] o_pins_oe, // Data pin output enables, high drives.
  output logic [7:0] o_fw_rdata, // Firmware read data.
  output psp_pkg::psp_status_t o_status, // Status flags.
  output logic o_irq // Masked interrupt request.
);
  import psp_pkg::*;

  // Access decode, shared by the current and the delayed strobe samples.
  function automatic logic access_on(input logic ok, input logic cs_n,
      input logic strobe_n);
    return ok && !cs_n && !strobe_n;
  endfunction : access_on

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  wire mode_on;
  wire strobes_ok;
  assign mode_on = i_port_e_direction[PSP_SEL_BIT];
  // Strobe pins count only as digital inputs when configured so.
  assign strobes_ok = mode_on && (&i_port_e_direction[2:0])
    && (i_analog_pin_config == PSP_ANALOG_DIGITAL);

  // ==========================================================================
  // Strobe synchronisers
  // ==========================================================================
  // Host strobes have no relation to our clock, so they are resynced
  // before any edge logic; this adds two cycles of latency.
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end else begin
      s1_q <= {i_cs_n, i_wr_n, i_rd_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire wr_act;
  wire rd_act;
  wire wr_act_old;
  wire rd_act_old;
  wire wr_done;
  wire rd_done;
  // Bit 2 is chip select, bit 1 the write and bit 0 the read strobe.
  assign wr_act = access_on(strobes_ok, s2_q[2], s2_q[1]);
  assign rd_act = access_on(strobes_ok, s2_q[2], s2_q[0]);
  assign wr_act_old = access_on(strobes_ok, s3_q[2], s3_q[1]);
  assign rd_act_old = access_on(strobes_ok, s3_q[2], s3_q[0]);
  assign wr_done = wr_act_old && !wr_act;
  assign rd_done = rd_act_old && !rd_act;

  // ==========================================================================
  // Phase counter
  // ==========================================================================
  logic [1:0] phase_q;
  wire ph2;
  wire ph4;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign ph2 = (phase_q == PSP_PH_TWO);
  assign ph4 = (phase_q == PSP_PH_FOUR);

  // ==========================================================================
  // Phased flag release
  // ==========================================================================
  // A write end and read end may each be pending; both share one tracker
  // because strobes from one master cannot overlap on distinct accesses.
  psp_pend_t pend_q;
  psp_pend_t pend_d;
  logic pend_wr_q;
  wire fire;
  assign fire = (pend_q == PSP_ST_WAIT4) && ph4;
  always_comb begin
    pend_d = pend_q;
    case (pend_q)
      PSP_ST_IDLE: begin
        if (wr_done || rd_done) begin
          pend_d = PSP_ST_WAIT2;
        end
      end
      PSP_ST_WAIT2: begin
        if (ph2) begin
          pend_d = PSP_ST_WAIT4;
        end
      end
      PSP_ST_WAIT4: begin
        if (ph4) begin
          pend_d = PSP_ST_IDLE;
        end
      end
      default: begin
        pend_d = PSP_ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Latches and flags
  // ==========================================================================
  logic [7:0] in_q;
  logic [7:0] out_q;
  logic ibf_q;
  logic obf_q;
  logic ovr_q;
  logic irq_q;
  logic rd_seen_q;
  logic [7:0] pins_q;
  logic [7:0] oe_q;
  logic [7:0] rdata_q;
  logic irq_out_q;

  wire set_ibf;
  wire set_irq;
  wire rd_latch;
  assign set_ibf = fire && pend_wr_q;
  assign set_irq = fire;
  assign rd_latch = i_fw.rd_data && !wr_act;
  // Host-visible drive value: a new firmware write shows at once.
  wire [7:0] out_next;
  assign out_next = i_fw.wr_data ? i_fw.wdata : out_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pend_q <= PSP_ST_IDLE;
    end else begin
      pend_q <= pend_d;
    end
  end

  // The data pins are still held by the host when the delayed strobe
  // shows the end of a write, so the capture sees settled data.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pend_wr_q <= 1'b0;
      in_q <= PSP_LATCH_RST;
    end else if (wr_done) begin
      pend_wr_q <= 1'b1;
      in_q <= i_pins;
    end else if (rd_done) begin
      pend_wr_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      out_q <= PSP_LATCH_RST;
    end else begin
      out_q <= out_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ibf_q <= 1'b0;
      obf_q <= 1'b0;
    end else if (!mode_on) begin
      ibf_q <= 1'b0;
      obf_q <= 1'b0;
    end else begin
      ibf_q <= set_ibf || (ibf_q && !rd_latch);
      if (rd_act) begin
        obf_q <= 1'b0;
      end else if (i_fw.wr_data) begin
        obf_q <= 1'b1;
      end
    end
  end

  // Set wins over a clear in the same cycle, so no event is lost.
  wire irq_d;
  assign irq_d = set_irq || (irq_q && !i_fw.clr_irq);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ovr_q <= 1'b0;
    end else if (set_ibf && ibf_q) begin
      ovr_q <= 1'b1;
    end else if (i_fw.clr_ovr && (rd_seen_q || rd_latch)) begin
      ovr_q <= 1'b0;
    end
  end

  // Remembers a latch read since the last write landed; the overrun
  // clear needs that read as well, in the same cycle or earlier.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rd_seen_q <= 1'b0;
    end else if (set_ibf) begin
      rd_seen_q <= 1'b0;
    end else if (rd_latch) begin
      rd_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  // Selection happens here; the blocks below only register it, so every
  // output leaves from a flip-flop at the cost of one cycle of latency.
  wire [7:0] pins_d;
  wire [7:0] oe_d;
  wire [7:0] rdata_d;
  assign pins_d = mode_on ? out_next : i_port_out_latch;
  assign oe_d = mode_on ? (rd_act ? 8'hff : 8'h00)
    : ~i_data_pin_direction;
  // While a host write is active firmware sees the live pins.
  assign rdata_d = (mode_on && !wr_act) ? in_q : i_pins;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pins_q <= PSP_LATCH_RST;
    end else begin
      pins_q <= pins_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      oe_q <= 8'h00;
    end else begin
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= PSP_LATCH_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_out_q <= 1'b0;
    end else begin
      irq_out_q <= irq_d && i_irq_enable;
    end
  end

  assign o_pins = pins_q;
  assign o_pins_oe = oe_q;
  assign o_fw_rdata = rdata_q;
  assign o_status = '{input_full_flag: ibf_q, output_full_flag: obf_q, ovr: ovr_q, irq_flag: irq_q};
  assign o_irq = irq_out_q;

endmodule : psp_port

// ### tb/psp_host_model.sv
// External bus master model for the parallel slave port.
`timescale 1ns/100ps
module psp_host_model (
  input wire logic i_core_clk, // Clock.
  input wire logic [7:0] i_drv, // Port drive.
  input wire logic [7:0] i_oe, // Port enables.
  output logic o_rd_n, // Read.
  output logic o_wr_n, // Write.
  output logic o_cs_n, // Select.
  output logic [7:0] o_bus // Bus level.
);
  logic [7:0] d_q = 8'h00;
  logic drv = 1'b0;
  initial {o_rd_n, o_wr_n, o_cs_n} = 3'b111;
  // Undriven bits show inverted old data, so stale values never pass.
  assign o_bus = (i_oe & i_drv) | (~i_oe & (drv ? d_q : ~d_q));
  // Strobes move 1 ns after a rising edge of the port clock.
  task automatic xfer(input logic wr, input logic [7:0] d,
      output logic [7:0] q);
    d_q = d;
    drv = wr;
    {o_rd_n, o_wr_n, o_cs_n} = {wr, !wr, 1'b0};
    repeat (6) @(posedge i_core_clk);
    #1;
    q = o_bus;
    {o_rd_n, o_wr_n, o_cs_n} = 3'b111;
    // Data is held past the rising strobe so the capture still sees it.
    repeat (4) @(posedge i_core_clk);
    #1;
    drv = 1'b0;
    repeat (12) @(posedge i_core_clk);
    #1;
  endtask : xfer
endmodule : psp_host_model

// ### tb/psp_port_properties.sv
// Port-level assertions for the parallel slave port.
`timescale 1ns/100ps
module psp_port_properties (
  input wire logic i_core_clk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic [7:0] i_port_e_direction, // Port E.
  input wire logic [3:0] i_analog_pin_config, // Config.
  input wire logic [7:0] i_data_pin_direction, // Data dir.
  input wire logic [7:0] i_port_out_latch, // Latch.
  input wire logic i_rd_n, // Read.
  input wire logic i_wr_n, // Write.
  input wire logic i_cs_n, // Select.
  input wire logic [7:0] i_pins, // Pins.
  input wire psp_pkg::psp_fw_req_t i_fw, // Firmware.
  input wire logic i_irq_enable, // Enable.
  input wire logic [7:0] o_pins, // Drive.
  input wire logic [7:0] o_pins_oe, // Enables.
  input wire logic [7:0] o_fw_rdata, // Read data.
  input wire psp_pkg::psp_status_t o_status, // Flags.
  input wire logic o_irq // Request.
);
  import psp_pkg::*;
  logic [3:0] idle_q;
  logic sel;
  assign sel = i_port_e_direction[PSP_SEL_BIT];
  // Quiet host cycles, so that phased flag updates have settled.
  always_ff @(posedge i_core_clk)
    idle_q <= (!i_rst_n || !i_cs_n) ? 4'h0 :
      (idle_q == 4'hf) ? idle_q : idle_q + 4'h1;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ========================
  // Assertions
  chk_irq_masked:
    assert property (o_irq |-> o_status.irq_flag && $past(i_irq_enable))
    else $error("request without flag and enable");
  chk_irq_sticky:
    assert property (o_status.irq_flag && !i_fw.clr_irq |=> o_status.irq_flag)
    else $error("irq flag lost");
  chk_full_off:
    assert property (!sel |=> !o_status.input_full_flag && !o_status.output_full_flag)
    else $error("full flag set with mode off");
  chk_ovr_kept:
    assert property (!sel && !i_fw.clr_ovr |=> $stable(o_status.ovr))
    else $error("overrun changed with mode off");
  chk_oe_release:
    assert property (sel && i_rd_n && o_pins_oe == 8'hff
      |-> ##[1:4] o_pins_oe == 8'h00)
    else $error("pins kept driven");
  chk_obf_read:
    assert property (sel && o_pins_oe == 8'hff |-> !o_status.output_full_flag)
    else $error("output full during read");
  chk_ibf_irq:
    assert property ($rose(o_status.input_full_flag) |-> o_status.irq_flag)
    else $error("input full without irq");
  chk_obf_set:
    assert property (sel && idle_q == 4'hf && i_fw.wr_data |=> o_status.output_full_flag)
    else $error("output full not set");
  cov_write: cover property ($rose(o_status.input_full_flag));
  cov_ovr: cover property ($rose(o_status.ovr));
  cov_read: cover property ($fell(o_pins_oe[0]));
endmodule : psp_port_properties
bind psp_port psp_port_properties u_props (.*);

// ### tb/test_psp_port.sv
// Self-checking bench for the parallel slave port.
`timescale 1ns/100ps
module test_psp_port;
  import psp_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] pe_dir = 8'h17;
  logic [3:0] acfg = PSP_ANALOG_DIGITAL;
  logic [7:0] d_dir = 8'hff;
  logic en = 1'b1;
  logic rd_n, wr_n, cs_n, irq;
  logic [7:0] pins, drv, oe, rdata, q;
  psp_fw_req_t fw = '0;
  psp_status_t st;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  initial forever #4 i_core_clk = ~i_core_clk;
  psp_port DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_port_e_direction(pe_dir), .i_analog_pin_config(acfg),
    .i_data_pin_direction(d_dir), .i_port_out_latch(8'h96),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_cs_n(cs_n), .i_pins(pins),
    .i_fw(fw), .i_irq_enable(en), .o_pins(drv), .o_pins_oe(oe),
    .o_fw_rdata(rdata), .o_status(st), .o_irq(irq));
  psp_host_model u_host (.i_core_clk(i_core_clk), .i_drv(drv),
    .i_oe(oe), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n), .o_bus(pins));
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Op bits are write, read, clear overrun, clear irq.
  task automatic fw_op(input logic [7:0] d, input logic [3:0] op);
    fw = {d, op};
    step(1);
    fw = '0;
    step(1);
  endtask : fw_op
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    step(12);
    i_rst_n = 1'b1;
    step(2);
    u_host.xfer(1'b1, 8'ha5, q);
    chk({5'h0, st.input_full_flag, st.irq_flag, irq}, 8'h07);
    fw_op(8'h00, 4'h4);
    chk(rdata, 8'ha5);
    chk({6'h0, st.input_full_flag, st.irq_flag}, 8'h01);
    fw_op(8'h00, 4'h1);
    chk({7'h0, st.irq_flag}, 8'h00);
    $display("test write done");
    u_host.xfer(1'b1, 8'h3c, q);
    u_host.xfer(1'b1, 8'hc3, q);
    chk({7'h0, st.ovr}, 8'h01);
    fw_op(8'h00, 4'h2);
    chk({7'h0, st.ovr}, 8'h01);
    fw_op(8'h00, 4'h4);
    chk(rdata, 8'hc3);
    fw_op(8'h00, 4'h3);
    chk({6'h0, st.ovr, st.irq_flag}, 8'h00);
    $display("test overrun done");
    fw_op(8'h5a, 4'h8);
    chk({7'h0, st.output_full_flag}, 8'h01);
    u_host.xfer(1'b0, 8'h00, q);
    chk(q, 8'h5a);
    chk({6'h0, st.output_full_flag, st.irq_flag}, 8'h01);
    chk(oe, 8'h00);
    en = 1'b0;
    step(2);
    chk({7'h0, irq}, 8'h00);
    en = 1'b1;
    fw_op(8'h00, 4'h1);
    $display("test read done");
    for (int i = 0; i < 2; i++) begin
      pe_dir = i ? 8'h17 : 8'h13;
      acfg = i ? 4'h0 : PSP_ANALOG_DIGITAL;
      u_host.xfer(1'b1, 8'h77, q);
      chk({7'h0, st.input_full_flag}, 8'h00);
    end
    acfg = PSP_ANALOG_DIGITAL;
    d_dir = 8'h00;
    step(2);
    chk(oe, 8'h00);
    d_dir = 8'hff;
    pe_dir = 8'h07;
    fw_op(8'h11, 4'h8);
    u_host.xfer(1'b1, 8'h42, q);
    chk({6'h0, st.input_full_flag, st.output_full_flag}, 8'h00);
    chk(drv, 8'h96);
    chk(oe, 8'h00);
    $display("test modes done");
    complete_run();
  end
endmodule : test_psp_port
